/* File: core/mmu_ctrl_regs.sv */
// Memory management control and status registers with index and pass-through
`timescale 1ns/1ps
`default_nettype none

module mmu_ctrl_regs #(
	parameter int WAYS_P = 4,
	parameter int PID_W_P = 8
) (
	// ----------------------------------------------------------
	// Clock and resets
	// ----------------------------------------------------------
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        manual_rst_in,

	// ----------------------------------------------------------
	// Memory-mapped register access
	// ----------------------------------------------------------
	input  wire logic        acc_valid_in,
	input  wire logic        acc_write_in,
	input  wire logic        acc_priv_in,
	input  wire logic [31:0] acc_addr_in,
	input  wire logic [31:0] acc_wdata_in,
	output logic             acc_hit_out,
	output logic             acc_rvalid_out,
	output logic      [31:0] acc_rdata_out,
	output logic             acc_error_out,

	// ----------------------------------------------------------
	// Exception events from the translation path
	// ----------------------------------------------------------
	input  wire logic        mmu_exc_in,
	input  wire logic        tlb_miss_in,
	input  wire logic        addr_err_in,
	input  wire logic [31:0] exc_vaddr_in,
	input  wire logic [1:0]  exc_way_in,
	input  wire logic [3:0]  miss_ways_valid_in,

	// ----------------------------------------------------------
	// Entry load towards the TLB array
	// ----------------------------------------------------------
	input  wire logic        load_entry_instruction_in,
	output logic             load_strobe_out,
	output logic      [21:0] load_vpn_out,
	output logic      [7:0]  load_pid_out,
	output logic      [31:0] load_entry_low_out,

	// ----------------------------------------------------------
	// Control towards the TLB array
	// ----------------------------------------------------------
	output logic             tlb_flush_out,
	output logic             single_virtual_mode_out,
	output logic             index_hash_mode_out,
	output logic             translation_enable_out,
	output logic      [1:0]  replacement_counter_out,
	output logic      [7:0]  process_identifier_out,

	// ----------------------------------------------------------
	// Lookup and address output
	// ----------------------------------------------------------
	input  wire logic [31:0] look_vaddr_in,
	input  wire logic [31:0] tlb_paddr_in,
	output logic      [4:0]  look_index_out,
	output logic             use_tlb_out,
	output logic      [31:0] phys_addr_out
);

	// ----------------------------------------------------------
	// Register state
	// ----------------------------------------------------------
	logic [31:0] entry_high_q;
	logic [31:0] entry_high_d;
	logic [31:0] entry_low_q;
	logic [31:0] entry_low_d;
	logic [31:0] table_base_q;
	logic [31:0] table_base_d;
	logic [31:0] fault_addr_q;
	logic [31:0] fault_addr_d;
	logic        at_q;
	logic        at_d;
	logic        ix_q;
	logic        ix_d;
	logic        sv_q;
	logic        sv_d;
	logic [1:0]  rc_q;
	logic [1:0]  rc_d;
	logic        flush_q;
	logic        load_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic        err_q;

	// ----------------------------------------------------------
	// Reset and access decode
	// ----------------------------------------------------------
	logic        any_rst;
	logic        sel_peh;
	logic        sel_pel;
	logic        sel_ttb;
	logic        sel_fa;
	logic        sel_ctl;
	logic        sel_any;
	logic        acc_ok;
	logic        wr_ok;
	logic        rd_ok;
	logic        wr_peh;
	logic        wr_pel;
	logic        wr_ttb;
	logic        wr_fa;
	logic        wr_ctl;
	logic        fault_evt;
	logic        mmu_evt;
	logic [1:0]  rc_evt;
	logic [31:0] ctl_view;
	logic [31:0] rd_mux;

	// Both reset sources initialise the same way
	assign any_rst = rst_in | manual_rst_in;

	assign sel_peh = acc_addr_in == mmu_ctrl_pkg::ADDR_PAGE_ENTRY_HIGH;
	assign sel_pel = acc_addr_in == mmu_ctrl_pkg::ADDR_PAGE_ENTRY_LOW;
	assign sel_ttb = acc_addr_in == mmu_ctrl_pkg::ADDR_TABLE_BASE;
	assign sel_fa  = acc_addr_in == mmu_ctrl_pkg::ADDR_FAULT_ADDRESS;
	assign sel_ctl = acc_addr_in == mmu_ctrl_pkg::ADDR_MMU_CONTROL;
	assign sel_any = sel_peh | sel_pel | sel_ttb | sel_fa | sel_ctl;

	// User-mode accesses are refused and flagged, nothing changes
	assign acc_ok = acc_valid_in & acc_priv_in & sel_any;
	assign wr_ok  = acc_ok & acc_write_in;
	assign rd_ok  = acc_ok & ~acc_write_in;
	assign wr_peh = wr_ok & sel_peh;
	assign wr_pel = wr_ok & sel_pel;
	assign wr_ttb = wr_ok & sel_ttb;
	assign wr_fa  = wr_ok & sel_fa;
	assign wr_ctl = wr_ok & sel_ctl;

	assign acc_hit_out = acc_valid_in & sel_any;

	// ----------------------------------------------------------
	// Control write fields
	// ----------------------------------------------------------
	// Slices named once so every next value reads the same field
	logic        wdat_at;
	logic        wdat_ix;
	logic        wdat_tf;
	logic        wdat_sv;
	logic [1:0]  wdat_rc;
	logic        flush_d;

	assign wdat_at = acc_wdata_in[mmu_ctrl_pkg::CTL_AT];
	assign wdat_ix = acc_wdata_in[mmu_ctrl_pkg::CTL_IX];
	assign wdat_tf = acc_wdata_in[mmu_ctrl_pkg::CTL_TF];
	assign wdat_sv = acc_wdata_in[mmu_ctrl_pkg::CTL_SV];
	assign wdat_rc = acc_wdata_in[mmu_ctrl_pkg::CTL_RC_LO +: 2];
	// Flush is only an order; nothing keeps the written bit
	assign flush_d = wr_ctl & wdat_tf;

	// ----------------------------------------------------------
	// Exception capture
	// ----------------------------------------------------------
	// An address error also records the faulting address
	assign fault_evt = mmu_exc_in | addr_err_in;
	// Replacement counter moves on translation exceptions, not on address errors
	assign mmu_evt   = mmu_exc_in;

	way_pick #(
		.WAYS_P (WAYS_P),
		.RC_W_P (mmu_ctrl_pkg::RC_W)
	) u_way_pick (
		.miss_in       (tlb_miss_in),
		.ways_valid_in (miss_ways_valid_in),
		.exc_way_in    (exc_way_in),
		.rc_in         (rc_q),
		.rc_out        (rc_evt)
	);

	// ----------------------------------------------------------
	// Next values
	// ----------------------------------------------------------
	// Hardware capture wins over a software write in the same cycle
	always_comb begin
		entry_high_d = entry_high_q;
		if (fault_evt) begin
			entry_high_d = (exc_vaddr_in & mmu_ctrl_pkg::PEH_VPN_MASK) |
				(entry_high_q & mmu_ctrl_pkg::PEH_PID_MASK);
		end else if (wr_peh) begin
			entry_high_d = acc_wdata_in & (mmu_ctrl_pkg::PEH_VPN_MASK |
				mmu_ctrl_pkg::PEH_PID_MASK);
		end
	end

	// Only software ever changes the entry-low word
	assign entry_low_d = wr_pel ?
		(acc_wdata_in & mmu_ctrl_pkg::PEL_MASK) : entry_low_q;

	// No hardware source feeds the table base
	assign table_base_d = wr_ttb ? acc_wdata_in : table_base_q;

	// Held until the next exception or a software write
	assign fault_addr_d = fault_evt ? exc_vaddr_in :
		wr_fa ? acc_wdata_in : fault_addr_q;

	assign at_d = wr_ctl ? wdat_at : at_q;
	assign ix_d = wr_ctl ? wdat_ix : ix_q;
	assign sv_d = wr_ctl ? wdat_sv : sv_q;

	// Exception update beats a software write of the counter
	assign rc_d = mmu_evt ? rc_evt :
		wr_ctl ? wdat_rc : rc_q;

	// ----------------------------------------------------------
	// Read view
	// ----------------------------------------------------------
	// Flush and bit 3 read zero, other unused bits as well
	always_comb begin
		ctl_view = mmu_ctrl_pkg::RST_WORD;
		ctl_view[mmu_ctrl_pkg::CTL_AT] = at_q;
		ctl_view[mmu_ctrl_pkg::CTL_IX] = ix_q;
		ctl_view[mmu_ctrl_pkg::CTL_TF] = 1'b0;
		ctl_view[mmu_ctrl_pkg::CTL_RC_LO +: 2] = rc_q;
		ctl_view[mmu_ctrl_pkg::CTL_SV] = sv_q;
	end

	assign rd_mux = sel_peh ? entry_high_q :
		sel_pel ? entry_low_q :
		sel_ttb ? table_base_q :
		sel_fa  ? fault_addr_q :
		sel_ctl ? ctl_view : mmu_ctrl_pkg::RST_WORD;

	// ----------------------------------------------------------
	// Register file
	// ----------------------------------------------------------
	// Undefined reset values are forced to zero for determinism
	always_ff @(posedge clk_sys_in) begin
		if (any_rst) begin
			entry_high_q <= mmu_ctrl_pkg::RST_WORD;
			entry_low_q  <= mmu_ctrl_pkg::RST_WORD;
			table_base_q <= mmu_ctrl_pkg::RST_WORD;
			fault_addr_q <= mmu_ctrl_pkg::RST_WORD;
		end else begin
			entry_high_q <= entry_high_d;
			entry_low_q  <= entry_low_d;
			table_base_q <= table_base_d;
			fault_addr_q <= fault_addr_d;
		end
	end

	// Mode bit has no defined reset value; zero is chosen
	always_ff @(posedge clk_sys_in) begin
		if (any_rst) begin
			at_q <= 1'b0;
			ix_q <= 1'b0;
			sv_q <= 1'b0;
			rc_q <= mmu_ctrl_pkg::RST_RC;
		end else begin
			at_q <= at_d;
			ix_q <= ix_d;
			sv_q <= sv_d;
			rc_q <= rc_d;
		end
	end

	// ----------------------------------------------------------
	// Strobes and read answer
	// ----------------------------------------------------------
	// Flush is a one-cycle pulse; the bit itself never stores
	always_ff @(posedge clk_sys_in) begin
		if (any_rst) begin
			flush_q <= 1'b0;
		end else begin
			flush_q <= flush_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (any_rst) begin
			load_q <= 1'b0;
		end else begin
			load_q <= load_entry_instruction_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (any_rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= mmu_ctrl_pkg::RST_WORD;
			err_q    <= 1'b0;
		end else begin
			rvalid_q <= rd_ok;
			rdata_q  <= rd_ok ? rd_mux : mmu_ctrl_pkg::RST_WORD;
			err_q    <= acc_valid_in & sel_any & ~acc_priv_in;
		end
	end

	assign acc_rvalid_out = rvalid_q;
	assign acc_rdata_out  = rdata_q;
	assign acc_error_out  = err_q;
	assign tlb_flush_out  = flush_q;

	// ----------------------------------------------------------
	// Entry load
	// ----------------------------------------------------------
	// Registered values are presented with the strobe
	assign load_strobe_out    = load_q;
	assign load_vpn_out       = entry_high_q[31:10];
	assign load_pid_out       = entry_high_q[PID_W_P-1:0];
	assign load_entry_low_out = entry_low_q;

	// ----------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------
	assign single_virtual_mode_out = sv_q;
	assign index_hash_mode_out     = ix_q;
	assign translation_enable_out  = at_q;
	assign replacement_counter_out = rc_q;
	assign process_identifier_out  = entry_high_q[PID_W_P-1:0];

	// ----------------------------------------------------------
	// Index and translation path
	// ----------------------------------------------------------
	logic [4:0] idx_plain;
	logic [4:0] idx_hash;
	logic [2:0] region;
	logic       fixed_region;

	assign idx_plain = look_vaddr_in[mmu_ctrl_pkg::IDX_LO +: 5];
	assign idx_hash  = idx_plain ^ entry_high_q[4:0];
	assign look_index_out = ix_q ? idx_hash : idx_plain;

	// Fixed regions and control space never consult the TLB
	assign region = look_vaddr_in[31:29];
	assign fixed_region = (region == mmu_ctrl_pkg::REG_CACHED_FIXED) |
		(region == mmu_ctrl_pkg::REG_UNCACHED_FIXED) |
		(region == mmu_ctrl_pkg::REG_CONTROL_SPACE);

	assign use_tlb_out = at_q & ~fixed_region;

	// Pass-through keeps shadow bits; the bus ignores them
	assign phys_addr_out = use_tlb_out ? tlb_paddr_in :
		look_vaddr_in;

endmodule
`default_nettype wire

/* File: core/mmu_ctrl_pkg.sv */
// Constants for the memory management control register set

package mmu_ctrl_pkg;

	// ----------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------
	localparam logic [31:0] ADDR_PAGE_ENTRY_HIGH = 32'hFFFFFF60;
	localparam logic [31:0] ADDR_PAGE_ENTRY_LOW  = 32'hFFFFFFF4;
	localparam logic [31:0] ADDR_TABLE_BASE      = 32'h0FFFFFF8;
	localparam logic [31:0] ADDR_FAULT_ADDRESS   = 32'hFFFFFFFC;
	localparam logic [31:0] ADDR_MMU_CONTROL     = 32'hFFFFFFE0;

	// ----------------------------------------------------------
	// Field layouts
	// ----------------------------------------------------------
	localparam logic [31:0] PEH_VPN_MASK  = 32'hFFFFFC00;
	localparam logic [31:0] PEH_PID_MASK  = 32'h000000FF;
	localparam logic [31:0] PEL_MASK      = 32'h1FFFFDFE;
	localparam int          PID_W         = 8;
	localparam int          IDX_LO        = 12;
	localparam int          IDX_W         = 5;
	localparam int          CTL_AT        = 0;
	localparam int          CTL_IX        = 1;
	localparam int          CTL_TF        = 2;
	localparam int          CTL_RC_LO     = 4;
	localparam int          CTL_SV        = 8;
	localparam int          RC_W          = 2;
	localparam int          WAYS          = 4;

	// ----------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------
	localparam logic [31:0] RST_WORD      = 32'h00000000;
	localparam logic [1:0]  RST_RC        = 2'h0;

	// ----------------------------------------------------------
	// Fixed regions (top address bits)
	// ----------------------------------------------------------
	localparam logic [2:0]  REG_CACHED_FIXED   = 3'h4;
	localparam logic [2:0]  REG_UNCACHED_FIXED = 3'h5;
	localparam logic [2:0]  REG_CONTROL_SPACE  = 3'h7;

endpackage

/* File: core/way_pick.sv */
// Replacement counter next-value selection
`timescale 1ns/1ps
`default_nettype none

module way_pick #(
	parameter int WAYS_P = 4,
	parameter int RC_W_P = 2
) (
	// Exception kind
	input  wire logic              miss_in,
	// Way state
	input  wire logic [WAYS_P-1:0] ways_valid_in,
	input  wire logic [RC_W_P-1:0] exc_way_in,
	input  wire logic [RC_W_P-1:0] rc_in,
	// Result
	output logic      [RC_W_P-1:0] rc_out
);

	logic              all_valid;
	logic [RC_W_P-1:0] low_inv;

	assign all_valid = &ways_valid_in;

	// Lowest-numbered invalid way wins
	always_comb begin
		low_inv = '0;
		for (int i = WAYS_P - 1; i >= 0; i--) begin
			if (!ways_valid_in[i]) begin
				low_inv = RC_W_P'(i);
			end
		end
	end

	assign rc_out = !miss_in ? exc_way_in :
		all_valid ? rc_in + RC_W_P'(1) :
		low_inv;

endmodule
`default_nettype wire

/* File: test/mmu_ctrl_regs_asserts.sv */
// Property checker for the memory management control registers
`timescale 1ns/1ps
`default_nettype none

module mmu_ctrl_regs_asserts #(
	parameter int WAYS_P  = 4,
	parameter int PID_W_P = 8
) (
	input wire logic        clk_sys_in,
	input wire logic        rst_in,
	input wire logic        manual_rst_in,
	input wire logic        acc_valid_in,
	input wire logic        acc_write_in,
	input wire logic        acc_priv_in,
	input wire logic [31:0] acc_addr_in,
	input wire logic [31:0] acc_wdata_in,
	input wire logic        acc_hit_out,
	input wire logic        acc_rvalid_out,
	input wire logic [31:0] acc_rdata_out,
	input wire logic        acc_error_out,
	input wire logic        mmu_exc_in,
	input wire logic        tlb_miss_in,
	input wire logic        addr_err_in,
	input wire logic [31:0] exc_vaddr_in,
	input wire logic [1:0]  exc_way_in,
	input wire logic [3:0]  miss_ways_valid_in,
	input wire logic        load_entry_instruction_in,
	input wire logic        load_strobe_out,
	input wire logic [21:0] load_vpn_out,
	input wire logic [7:0]  load_pid_out,
	input wire logic [31:0] load_entry_low_out,
	input wire logic        tlb_flush_out,
	input wire logic        index_hash_mode_out,
	input wire logic        translation_enable_out,
	input wire logic [1:0]  replacement_counter_out,
	input wire logic [7:0]  process_identifier_out,
	input wire logic [31:0] look_vaddr_in,
	input wire logic [4:0]  look_index_out,
	input wire logic        use_tlb_out,
	input wire logic [31:0] phys_addr_out
);
	wire logic rst_any = rst_in || manual_rst_in;
	wire logic wr_ok = acc_valid_in && acc_write_in && acc_priv_in;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_any);

	sequence rd_req_s;
		acc_valid_in && !acc_write_in && acc_priv_in && acc_hit_out;
	endsequence
	sequence miss_s;
		mmu_exc_in && tlb_miss_in;
	endsequence

	rst_clear_a: assert property (disable iff (1'b0) rst_any |=>
		!translation_enable_out && !index_hash_mode_out
		&& replacement_counter_out == 2'h0)
		else $error("control not cleared by reset");
	rd_answer_a: assert property (rd_req_s |=> acc_rvalid_out)
		else $error("read not answered");
	user_refused_a: assert property (acc_valid_in && !acc_priv_in
		&& acc_hit_out |=> acc_error_out && !acc_rvalid_out)
		else $error("user access not refused");
	flush_pulse_a: assert property (wr_ok && acc_wdata_in[2]
		&& acc_addr_in == mmu_ctrl_pkg::ADDR_MMU_CONTROL |=> tlb_flush_out)
		else $error("flush pulse missing");
	ctrl_zeros_a: assert property (acc_rvalid_out
		&& $past(acc_addr_in) == mmu_ctrl_pkg::ADDR_MMU_CONTROL
		|-> (acc_rdata_out & 32'hFFFFFECC) == 32'h0)
		else $error("control reserved bits not zero");
	vpn_capture_a: assert property ((mmu_exc_in || addr_err_in)
		|=> load_vpn_out == $past(exc_vaddr_in[31:10]))
		else $error("page number not captured");
	full_incr_a: assert property (miss_s ##0 miss_ways_valid_in == 4'hF
		|=> replacement_counter_out == $past(replacement_counter_out) + 2'h1)
		else $error("counter not incremented");
	other_way_a: assert property (mmu_exc_in && !tlb_miss_in
		|=> replacement_counter_out == $past(exc_way_in))
		else $error("faulting way not loaded");
	low_hold_a: assert property ($changed(load_entry_low_out) |->
		$past(wr_ok && acc_addr_in == mmu_ctrl_pkg::ADDR_PAGE_ENTRY_LOW)
		|| $past(rst_any))
		else $error("entry low changed without write");
	index_calc_a: assert property (look_index_out == (look_vaddr_in[16:12]
		^ (index_hash_mode_out ? process_identifier_out[4:0] : 5'h00)))
		else $error("lookup index wrong");
	pass_thru_a: assert property (!translation_enable_out |->
		!use_tlb_out && phys_addr_out == look_vaddr_in)
		else $error("address not passed through");
	load_copy_a: assert property (load_entry_instruction_in |=>
		load_strobe_out && load_pid_out == process_identifier_out)
		else $error("entry load not issued");
endmodule

bind mmu_ctrl_regs mmu_ctrl_regs_asserts #(.WAYS_P(WAYS_P), .PID_W_P(PID_W_P))
	u_mmu_ctrl_regs_asserts (.*);
`default_nettype wire

/* File: test/mmu_ctrl_regs_tb_top.sv */
// Self-checking testbench for the memory management control registers
`timescale 1ns/1ps
`default_nettype none

module mmu_ctrl_regs_tb_top;
	logic        clk_sys_in, rst_in, manual_rst_in;
	logic        acc_valid_in, acc_write_in, acc_priv_in, acc_hit_out;
	logic [31:0] acc_addr_in, acc_wdata_in, acc_rdata_out, rd;
	logic        acc_rvalid_out, acc_error_out, rv, er;
	logic        mmu_exc_in, tlb_miss_in, addr_err_in;
	logic [31:0] exc_vaddr_in, look_vaddr_in, tlb_paddr_in, phys_addr_out;
	logic [1:0]  exc_way_in, replacement_counter_out;
	logic [3:0]  miss_ways_valid_in;
	logic        load_entry_instruction_in, load_strobe_out, tlb_flush_out;
	logic [21:0] load_vpn_out;
	logic [7:0]  load_pid_out, process_identifier_out;
	logic [31:0] load_entry_low_out;
	logic        single_virtual_mode_out, index_hash_mode_out;
	logic        translation_enable_out, use_tlb_out;
	logic [4:0]  look_index_out;
	int          errors, compares;
	localparam logic [31:0] ADR [5] = '{mmu_ctrl_pkg::ADDR_PAGE_ENTRY_HIGH,
		mmu_ctrl_pkg::ADDR_PAGE_ENTRY_LOW, mmu_ctrl_pkg::ADDR_TABLE_BASE,
		mmu_ctrl_pkg::ADDR_FAULT_ADDRESS, mmu_ctrl_pkg::ADDR_MMU_CONTROL};
	// Readable bits of each register, same order as the addresses
	localparam logic [31:0] MSK [5] = '{32'hFFFFFCFF, 32'h1FFFFDFE,
		32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000133};

	mmu_ctrl_regs u_mmu_ctrl_regs (.*);

	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	task automatic finish_test();
		if (errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tick();
		@(posedge clk_sys_in);
		#2;
	endtask

	// Request is held to the next edge; valid stays up for back-to-back use
	task automatic acc(input logic w, p, input logic [31:0] a, d);
		acc_valid_in = 1'b1;
		acc_write_in = w;
		acc_priv_in = p;
		acc_addr_in = a;
		acc_wdata_in = d;
		tick();
		rd = acc_rdata_out;
		rv = acc_rvalid_out;
		er = acc_error_out;
	endtask

	task automatic idle();
		acc_valid_in = 1'b0;
		mmu_exc_in = 1'b0;
		addr_err_in = 1'b0;
		tick();
	endtask

	task automatic exc(input logic m, ms, ae, input logic [3:0] v,
		input logic [1:0] w, input logic [31:0] va);
		mmu_exc_in = m;
		tlb_miss_in = ms;
		addr_err_in = ae;
		miss_ways_valid_in = v;
		exc_way_in = w;
		exc_vaddr_in = va;
		tick();
	endtask

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 5; i++) begin
			acc(1'b0, 1'b1, ADR[i], 32'h0);
			chk(rd, 32'h0);
			// Reserved control bits are written as zero
			acc(1'b1, 1'b1, ADR[i], (i == 4) ? 32'h00000137 : 32'hFFFFFFFF);
			if (i == 4) chk(tlb_flush_out, 1'b1);
			acc(1'b0, 1'b1, ADR[i], 32'h0);
			chk(rd, MSK[i]);
			if (i == 4) chk(single_virtual_mode_out, 1'b1);
			acc(1'b1, 1'b1, ADR[i], 32'h0);
		end
		idle();
	endtask

	task automatic t_priv();
		acc(1'b1, 1'b0, mmu_ctrl_pkg::ADDR_TABLE_BASE, 32'h00AA55AA);
		chk(er, 1'b1);
		acc(1'b0, 1'b0, mmu_ctrl_pkg::ADDR_TABLE_BASE, 32'h0);
		chk({rv, er}, 2'h1);
		acc(1'b0, 1'b1, 32'hFFFFFF00, 32'h0);
		chk({rv, er}, 2'h0);
		chk(acc_hit_out, 1'b0);
		acc(1'b0, 1'b1, mmu_ctrl_pkg::ADDR_TABLE_BASE, 32'h0);
		chk(rd, 32'h0);
		chk(acc_hit_out, 1'b1);
		idle();
	endtask

	task automatic t_exc();
		logic [1:0] exp;
		acc(1'b1, 1'b1, mmu_ctrl_pkg::ADDR_PAGE_ENTRY_HIGH, 32'h0000005A);
		idle();
		for (int i = 0; i < 15; i++) begin
			exp = 2'h0;
			for (int j = 3; j >= 0; j--) if (!i[j]) exp = j[1:0];
			exc(1'b1, 1'b1, 1'b0, i[3:0], 2'h0, 32'h12345678);
			chk(replacement_counter_out, exp);
		end
		exc(1'b1, 1'b1, 1'b0, 4'hF, 2'h0, 32'h12345678);
		chk(replacement_counter_out, 2'h1);
		exc(1'b1, 1'b1, 1'b0, 4'hF, 2'h0, 32'h12345678);
		chk(replacement_counter_out, 2'h2);
		exc(1'b1, 1'b0, 1'b0, 4'h0, 2'h1, 32'h12345678);
		chk(replacement_counter_out, 2'h1);
		exc(1'b0, 1'b0, 1'b1, 4'h0, 2'h3, 32'hABCDE7FF);
		idle();
		repeat (3) tick();
		acc(1'b0, 1'b1, mmu_ctrl_pkg::ADDR_FAULT_ADDRESS, 32'h0);
		chk(rd, 32'hABCDE7FF);
		acc(1'b0, 1'b1, mmu_ctrl_pkg::ADDR_PAGE_ENTRY_HIGH, 32'h0);
		chk(rd, 32'hABCDE45A);
		acc(1'b0, 1'b1, mmu_ctrl_pkg::ADDR_PAGE_ENTRY_LOW, 32'h0);
		chk(rd, 32'h0);
		idle();
	endtask

	task automatic t_load();
		logic [31:0] peh;
		peh = 32'hABCDE45A;
		acc(1'b1, 1'b1, mmu_ctrl_pkg::ADDR_PAGE_ENTRY_LOW, 32'hFFFFFFFF);
		idle();
		load_entry_instruction_in = 1'b1;
		tick();
		load_entry_instruction_in = 1'b0;
		chk(load_strobe_out, 1'b1);
		chk(load_vpn_out, peh[31:10]);
		chk(load_pid_out, 8'h5A);
		chk(load_entry_low_out, 32'h1FFFFDFE);
		tick();
		chk(load_strobe_out, 1'b0);
	endtask

	task automatic t_index();
		acc(1'b1, 1'b1, mmu_ctrl_pkg::ADDR_MMU_CONTROL, 32'h00000003);
		idle();
		look_vaddr_in = 32'h00015000;
		tick();
		chk(look_index_out, 5'h15 ^ 5'h1A);
		chk(use_tlb_out, 1'b1);
		chk(phys_addr_out, 32'h00ABC000);
		look_vaddr_in = 32'hA0015000;
		tick();
		chk(use_tlb_out, 1'b0);
		chk(phys_addr_out, 32'hA0015000);
		acc(1'b1, 1'b1, mmu_ctrl_pkg::ADDR_MMU_CONTROL, 32'h0);
		idle();
		look_vaddr_in = 32'h00015000;
		tick();
		chk(look_index_out, 5'h15);
		chk(use_tlb_out, 1'b0);
		chk(phys_addr_out, 32'h00015000);
	endtask

	task automatic t_manual();
		acc(1'b1, 1'b1, mmu_ctrl_pkg::ADDR_MMU_CONTROL, 32'h00000133);
		idle();
		manual_rst_in = 1'b1;
		tick();
		manual_rst_in = 1'b0;
		acc(1'b0, 1'b1, mmu_ctrl_pkg::ADDR_MMU_CONTROL, 32'h0);
		chk(rd, 32'h0);
		acc(1'b0, 1'b1, mmu_ctrl_pkg::ADDR_PAGE_ENTRY_HIGH, 32'h0);
		chk(rd, 32'h0);
		idle();
	endtask

	initial begin
		{rst_in, manual_rst_in, acc_valid_in, acc_write_in} = 4'h8;
		{acc_priv_in, mmu_exc_in, tlb_miss_in, addr_err_in} = 4'h0;
		{acc_addr_in, acc_wdata_in, exc_vaddr_in} = 96'h0;
		{exc_way_in, miss_ways_valid_in, load_entry_instruction_in} = 7'h0;
		look_vaddr_in = 32'h0;
		tlb_paddr_in = 32'h00ABC000;
		errors = 0;
		compares = 0;
		repeat (4) @(posedge clk_sys_in);
		#2;
		rst_in = 1'b0;
		t_regs();
		t_priv();
		t_exc();
		t_load();
		t_index();
		t_manual();
		finish_test();
	end

	// Whole run is well under 200 cycles; this bound catches a hang
	initial begin
		#(25 * 2000);
		errors++;
		finish_test();
	end
endmodule
`default_nettype wire
